// ==== design/aics_pkg.sv ====
// Purpose: Constants and carriers for the ADC input channel select block
// Assumes: Classic Wishbone slave, 32-bit data, channel and scan registers in low 16 bits
// Notes: Offsets are byte addresses of aligned words
`default_nettype none
package aics_pkg;
   localparam logic [3:0] AICS_OFF_CHS0 = 4'h0;
   localparam logic [3:0] AICS_OFF_CSSH = 4'h4;
   localparam logic [3:0] AICS_OFF_OPA = 4'h8;
   localparam logic [3:0] AICS_OFF_ROUTE = 4'hc;
   localparam int AICS_POS_NEG_A = 7;
   localparam int AICS_POS_NEG_B = 15;
   localparam int AICS_POS_SB_LO = 8;
   localparam int AICS_POS_SA_LO = 0;
   localparam int AICS_POS_SCAN16 = 0;
   localparam int AICS_POS_SCAN17 = 1;
   localparam logic [15:0] AICS_CHS0_MASK = 16'hbfbf;
   localparam logic [15:0] AICS_CHS0_RST = 16'h0000;
   localparam logic [15:0] AICS_CSSH_RST = 16'h0000;
   localparam logic [31:0] AICS_PRESENT_DEF = 32'h0000ffff;
   localparam logic [31:0] AICS_OPA_RST = 32'h00000000;
   localparam logic [31:0] AICS_UNMAPPED = 32'h00000000;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } aics_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } aics_wb_rsp_t;

   typedef struct packed {
      logic neg_a_pin_one;
      logic neg_b_pin_one;
      logic [5:0] pos_a_code;
      logic [5:0] pos_b_code;
      logic pos_a_op_amp;
      logic pos_b_op_amp;
      logic pos_a_low_ref;
      logic pos_b_low_ref;
      logic scan_sixteen_en;
      logic scan_seventeen_en;
      logic scan_sixteen_op_amp;
      logic scan_seventeen_op_amp;
      logic scan_sixteen_low_ref;
      logic scan_seventeen_low_ref;
   } aics_route_t;
endpackage : aics_pkg
`default_nettype wire

// ==== design/aics_route.sv ====
// Purpose: Turns one input number into its analog route
// Assumes: Presence and op amp maps indexed by input number
// Notes: Pure combinational
`timescale 1ns/1ps
`default_nettype none
module aics_route (
   input wire logic [5:0] code,
   input wire logic [31:0] present,
   input wire logic [31:0] op_amp_enable,
   output logic op_amp,
   output logic low_ref
);
   import aics_pkg::*;
   logic in_range;
   assign in_range = (code[5] == 1'b0);
   // Missing inputs convert the low reference
   assign low_ref = !in_range || !present[code[4:0]];
   assign op_amp = in_range && present[code[4:0]] && op_amp_enable[code[4:0]];
endmodule : aics_route
`default_nettype wire

// ==== design/aics_top.sv ====
// Purpose: ADC input channel select registers and analog route outputs
// Assumes: Classic Wishbone, one wait-free ack a cycle after the strobe
// Notes: Op amp enable copies kept locally, one bit per input number
// Behaviour
// - Mux A negative bit: pin one or low reference
// - Scan bit seventeen includes or skips input
// - Scan bit sixteen includes or skips input
// - Op amp enable routes op amp output
// - Missing inputs sample the low reference
// - All scan-high bits stay software writable
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module aics_top #(
   parameter logic [31:0] PRESENT = aics_pkg::AICS_PRESENT_DEF
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire aics_pkg::aics_wb_req_t wb_req,
   output aics_pkg::aics_wb_rsp_t wb_rsp,
   output aics_pkg::aics_route_t route
);
   import aics_pkg::*;

   typedef struct packed {
      logic [15:0] chs0;
      logic [15:0] cssh;
      logic [31:0] opa;
      logic ack;
      logic [31:0] rdat;
      aics_route_t route;
   } aics_state_t;

   aics_state_t st_ff;
   aics_state_t nxt_st;
   logic a_op, a_lr, b_op, b_lr, s16_op, s16_lr, s17_op, s17_lr;

   function automatic logic [31:0] aics_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : aics_merge

   aics_route u_a (
      .code(st_ff.chs0[AICS_POS_SA_LO +: 6]),
      .present(PRESENT),
      .op_amp_enable(st_ff.opa),
      .op_amp(a_op),
      .low_ref(a_lr)
   );
   aics_route u_b (
      .code(st_ff.chs0[AICS_POS_SB_LO +: 6]),
      .present(PRESENT),
      .op_amp_enable(st_ff.opa),
      .op_amp(b_op),
      .low_ref(b_lr)
   );
   aics_route u_s16 (
      .code(6'h10),
      .present(PRESENT),
      .op_amp_enable(st_ff.opa),
      .op_amp(s16_op),
      .low_ref(s16_lr)
   );
   aics_route u_s17 (
      .code(6'h11),
      .present(PRESENT),
      .op_amp_enable(st_ff.opa),
      .op_amp(s17_op),
      .low_ref(s17_lr)
   );

   always_comb begin
      logic req;
      logic [31:0] m;
      req = 1'b0;
      m = 32'h00000000;
      nxt_st = st_ff;
      req = wb_req.cyc && wb_req.stb && !st_ff.ack;
      nxt_st.ack = req;
      if (req && wb_req.we) begin
         unique case (wb_req.adr)
            AICS_OFF_CHS0: begin
               m = aics_merge({16'h0000, st_ff.chs0}, wb_req.dat, wb_req.sel);
               nxt_st.chs0 = m[15:0] & AICS_CHS0_MASK;
            end
            AICS_OFF_CSSH: begin
               // Every bit writable even where no input exists
               m = aics_merge({16'h0000, st_ff.cssh}, wb_req.dat, wb_req.sel);
               nxt_st.cssh = m[15:0];
            end
            AICS_OFF_OPA: begin
               nxt_st.opa = aics_merge(st_ff.opa, wb_req.dat, wb_req.sel);
            end
            default: begin
            end
         endcase
      end
      if (req) begin
         unique case (wb_req.adr)
            AICS_OFF_CHS0: nxt_st.rdat = {16'h0000, st_ff.chs0};
            AICS_OFF_CSSH: nxt_st.rdat = {16'h0000, st_ff.cssh};
            AICS_OFF_OPA: nxt_st.rdat = st_ff.opa;
            AICS_OFF_ROUTE: nxt_st.rdat = {8'h00, st_ff.route};
            default: nxt_st.rdat = AICS_UNMAPPED;
         endcase
      end
      nxt_st.route.neg_a_pin_one = st_ff.chs0[AICS_POS_NEG_A];
      nxt_st.route.neg_b_pin_one = st_ff.chs0[AICS_POS_NEG_B];
      nxt_st.route.pos_a_code = st_ff.chs0[AICS_POS_SA_LO +: 6];
      nxt_st.route.pos_b_code = st_ff.chs0[AICS_POS_SB_LO +: 6];
      nxt_st.route.pos_a_op_amp = a_op;
      nxt_st.route.pos_b_op_amp = b_op;
      nxt_st.route.pos_a_low_ref = a_lr;
      nxt_st.route.pos_b_low_ref = b_lr;
      nxt_st.route.scan_sixteen_en = st_ff.cssh[AICS_POS_SCAN16];
      nxt_st.route.scan_seventeen_en = st_ff.cssh[AICS_POS_SCAN17];
      nxt_st.route.scan_sixteen_op_amp = s16_op;
      nxt_st.route.scan_seventeen_op_amp = s17_op;
      nxt_st.route.scan_sixteen_low_ref = s16_lr;
      nxt_st.route.scan_seventeen_low_ref = s17_lr;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_rsp.ack = st_ff.ack;
   assign wb_rsp.dat = st_ff.rdat;
   assign route = st_ff.route;

   // Route outputs lag the register by one cycle
   property p_neg_a;
      @(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> route.neg_a_pin_one == $past(st_ff.chs0[AICS_POS_NEG_A]);
   endproperty
   a_neg_a: assert property (p_neg_a) else $error("neg a route wrong");

   property p_scan17;
      @(posedge ref_clk) disable iff (!resetn)
      (st_ff.ack && $past(wb_req.we) && $past(wb_req.adr) == AICS_OFF_CSSH
       && $past(wb_req.sel[0]))
      |=> route.scan_seventeen_en == $past(wb_req.dat[AICS_POS_SCAN17], 2);
   endproperty
   a_scan17: assert property (p_scan17) else $error("scan 17 wrong");

   property p_scan16;
      @(posedge ref_clk) disable iff (!resetn)
      (st_ff.ack && $past(wb_req.we) && $past(wb_req.adr) == AICS_OFF_CSSH
       && $past(wb_req.sel[0]))
      |=> route.scan_sixteen_en == $past(wb_req.dat[AICS_POS_SCAN16], 2);
   endproperty
   a_scan16: assert property (p_scan16) else $error("scan 16 wrong");

   // Present input with its op amp on must take the op amp, never low ref
   property p_opa_excl;
      @(posedge ref_clk) disable iff (!resetn)
      (!st_ff.chs0[AICS_POS_SB_LO + 5] && PRESENT[st_ff.chs0[AICS_POS_SB_LO +: 5]]
       && st_ff.opa[st_ff.chs0[AICS_POS_SB_LO +: 5]])
      |=> route.pos_b_op_amp && !route.pos_b_low_ref;
   endproperty
   a_opa_excl: assert property (p_opa_excl) else $error("op amp not routed");

   property p_lowref;
      @(posedge ref_clk) disable iff (!resetn)
      st_ff.chs0[AICS_POS_SB_LO + 5] |=> route.pos_b_low_ref;
   endproperty
   a_lowref: assert property (p_lowref) else $error("missing input not low ref");

   sequence s_cssh_write;
      wb_req.cyc && wb_req.stb && wb_req.we && !st_ff.ack
      && wb_req.adr == AICS_OFF_CSSH && wb_req.sel[1:0] == 2'b11;
   endsequence
   property p_cssh_wr;
      @(posedge ref_clk) disable iff (!resetn)
      s_cssh_write |=> st_ff.cssh == $past(wb_req.dat[15:0]);
   endproperty
   a_cssh_wr: assert property (p_cssh_wr) else $error("scan high not writable");

   property p_posb;
      @(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> route.pos_b_code == $past(st_ff.chs0[13:8]);
   endproperty
   a_posb: assert property (p_posb) else $error("pos b code wrong");

   property p_ack_once;
      @(posedge ref_clk) disable iff (!resetn)
      st_ff.ack |=> !st_ff.ack;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
endmodule : aics_top
`default_nettype wire

// ==== verification/aics_mux_model.sv ====
// Purpose: Analog mux model, reports the source the negative A, scan 16 and scan 17 routes pick
// Assumes: Codes 0 low reference, 1 pin, 2 op amp output
// Notes: Missing input wins over op amp, nothing to sample there
`timescale 1ns/1ps
`default_nettype none
module aics_mux_model (
   input wire aics_pkg::aics_route_t route,
   output logic [1:0] neg_a_src,
   output logic [1:0] scan16_src,
   output logic [1:0] scan17_src
);
   import aics_pkg::*;
   assign neg_a_src = {1'b0, route.neg_a_pin_one};
   assign scan16_src = route.scan_sixteen_low_ref ? 2'h0 :
      (route.scan_sixteen_op_amp ? 2'h2 : 2'h1);
   assign scan17_src = route.scan_seventeen_low_ref ? 2'h0 :
      (route.scan_seventeen_op_amp ? 2'h2 : 2'h1);
endmodule : aics_mux_model
`default_nettype wire

// ==== verification/test_aics.sv ====
// Purpose: Self-checking bench for the input channel select block
// Assumes: Input 16 present, input 17 missing
// Notes: Ack sampled at the edge, request released there
`timescale 1ns/1ps
`default_nettype none
module test_aics;
   import aics_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   aics_wb_req_t wb_req = '0;
   aics_wb_rsp_t wb_rsp;
   aics_route_t route;
   logic [1:0] neg_a_src;
   logic [1:0] scan16_src;
   logic [1:0] scan17_src;
   logic [31:0] rd;
   int err_count = 0;
   int comparisons = 0;
   always #4 ref_clk = ~ref_clk;
   aics_top #(.PRESENT(32'h0001ffff)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .wb_req(wb_req), .wb_rsp(wb_rsp), .route(route));
   aics_mux_model mux_u (.route(route), .neg_a_src(neg_a_src),
      .scan16_src(scan16_src), .scan17_src(scan17_src));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge ref_clk);
      @(posedge ref_clk);
   endtask : wb
   task automatic t_chs0();
      wb(1'b0, AICS_OFF_CHS0, 32'h0);
      chk("chs0 reset", {16'h0, AICS_CHS0_RST}, rd);
      wb(1'b1, AICS_OFF_CHS0, 32'hffffffff);
      wb(1'b0, AICS_OFF_CHS0, 32'h0);
      chk("chs0 rw", {16'h0, AICS_CHS0_MASK}, rd);
      chk("neg a", 32'h1, {31'h0, route.neg_a_pin_one});
      wb(1'b1, AICS_OFF_CHS0, 32'h1f00);
      chk("code b", 32'h1f, {26'h0, route.pos_b_code});
      chk("neg a src", 32'h0, {30'h0, neg_a_src});
      wb(1'b1, AICS_OFF_CHS0, 32'h2000);
      chk("b low ref", 32'h1, {31'h0, route.pos_b_low_ref});
      wb(1'b1, AICS_OFF_CHS0, 32'h1100);
      chk("b low ref", 32'h1, {31'h0, route.pos_b_low_ref});
      wb(1'b1, AICS_OFF_CHS0, 32'h0100);
      chk("code b", 32'h1, {26'h0, route.pos_b_code});
      chk("b low ref", 32'h0, {31'h0, route.pos_b_low_ref});
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", AICS_UNMAPPED, rd);
   endtask : t_chs0
   task automatic t_scan();
      wb(1'b1, AICS_OFF_CSSH, 32'hffffffff);
      wb(1'b0, AICS_OFF_CSSH, 32'h0);
      chk("cssh rw", 32'h0000ffff, rd);
      chk("scan16", 32'h1, {31'h0, route.scan_sixteen_en});
      chk("scan17", 32'h1, {31'h0, route.scan_seventeen_en});
      chk("scan17 src", 32'h0, {30'h0, scan17_src});
      chk("scan16 src", 32'h1, {30'h0, scan16_src});
      wb(1'b1, AICS_OFF_CSSH, 32'h1);
      chk("scan17", 32'h0, {31'h0, route.scan_seventeen_en});
      wb(1'b1, AICS_OFF_CSSH, 32'h2);
      chk("scan16", 32'h0, {31'h0, route.scan_sixteen_en});
   endtask : t_scan
   task automatic t_opamp();
      wb(1'b1, AICS_OFF_OPA, 32'h00030002);
      chk("scan16 src", 32'h2, {30'h0, scan16_src});
      chk("scan17 src", 32'h0, {30'h0, scan17_src});
      chk("b op amp", 32'h1, {31'h0, route.pos_b_op_amp});
      chk("b low ref", 32'h0, {31'h0, route.pos_b_low_ref});
      wb(1'b1, AICS_OFF_OPA, 32'h0);
      chk("scan16 src", 32'h1, {30'h0, scan16_src});
      chk("b op amp", 32'h0, {31'h0, route.pos_b_op_amp});
   endtask : t_opamp
   task automatic report_and_stop();
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_chs0();
      t_scan();
      t_opamp();
      report_and_stop();
   end
   initial begin
      #20000;
      err_count++;
      report_and_stop();
   end
endmodule : test_aics
`default_nettype wire
